// >>> rtl/rix_pkg.sv
// package: constants, encodings and carriers of the execute core
package rix_pkg;

  // timing: one instruction cycle spans four oscillator periods
  localparam int unsigned OSC_PER_CYCLE = 4;

  // widths
  localparam int unsigned PC_W   = 11;
  localparam int unsigned INS_W  = 12;
  localparam int unsigned DAT_W  = 8;
  localparam int unsigned FADR_W = 5;

  // apb register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] ACC_OFS    = 8'h08;
  localparam logic [7:0] PC_OFS     = 8'h0C;
  localparam logic [7:0] WDOG_OFS   = 8'h10;

  // control register fields and reset value
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned CTRL_PSA_BIT = 1;
  localparam logic [1:0]  CTRL_RESET   = 2'h1;

  // status byte fields and reset value
  localparam int unsigned ST_C   = 0;
  localparam int unsigned ST_DC  = 1;
  localparam int unsigned ST_Z   = 2;
  localparam int unsigned ST_PD  = 3;
  localparam int unsigned ST_TO  = 4;
  localparam int unsigned ST_PA0 = 5;
  localparam int unsigned ST_PA1 = 6;
  localparam int unsigned ST_WUF = 7;
  localparam logic [7:0]  STATUS_RESET = 8'h18;

  // instruction encodings (full words and prefixes)
  localparam logic [11:0] NOP_WORD      = 12'h000;
  localparam logic [11:0] WDCLR_WORD    = 12'h004;
  localparam logic [11:0] SLEEP_WORD    = 12'h003;
  localparam logic [11:0] CLRACC_WORD   = 12'h040;
  localparam logic [6:0]  CLRFILE_PFX   = 7'h03;
  localparam logic [5:0]  DEC_PFX       = 6'h03;
  localparam logic [5:0]  DECSKIP_PFX   = 6'h0B;
  localparam logic [5:0]  ORFILE_PFX    = 6'h04;
  localparam logic [5:0]  MOVFILE_PFX   = 6'h08;
  localparam logic [5:0]  SUB_PFX       = 6'h02;
  localparam logic [5:0]  XORFILE_PFX   = 6'h06;
  localparam logic [3:0]  CALL_PFX      = 4'h9;
  localparam logic [2:0]  BRANCH_PFX    = 3'h5;
  localparam logic [3:0]  ORLIT_PFX     = 4'hD;
  localparam logic [3:0]  MOVLIT_PFX    = 4'hC;
  localparam logic [3:0]  XORLIT_PFX    = 4'hF;

  // decoded operation
  typedef enum logic [3:0] {
    OP_NONE, OP_CALL, OP_BRANCH, OP_CLRFILE, OP_CLRACC, OP_WDCLR,
    OP_DEC, OP_DECSKIP, OP_ORLIT, OP_ORFILE, OP_MOVFILE, OP_MOVLIT,
    OP_SUB, OP_XORLIT, OP_XORFILE, OP_SLEEP
  } rix_op_type;

  // core run state
  typedef enum logic {ST_RUN, ST_STANDBY} rix_state_type;

  // request toward the file register space
  typedef struct packed {
    logic [4:0] addr;  // addressed file register
    logic [7:0] wdata; // value written back
    logic       we;    // one pclk write strobe
  } rix_file_req_type;

endpackage

// >>> rtl/rix_core.sv
// execute core for a subset of a 12-bit-instruction 8-bit-data risc machine
//
// How it works
// - call pushes return address, takes two cycles
// - call target: literal, page bits, bit8 zero
// - clear file writes zero, sets zero
// - clear accumulator writes zero, sets zero
// - watchdog clear resets counter, sets timeout, powerdown
// - destination bit picks accumulator or file
// - decrement file, route result, update zero
// - decrement skip: no flags, flush on zero
// - branch loads nine bits plus page bits
// - or literal into accumulator, update zero
// - or file to destination, update zero
// - move file updates zero even onto itself
// - move literal loads accumulator, flags untouched
// - sleep clears watchdog, timeout set, powerdown cleared
// - after sleep core stands by, clock halted
// - subtract file minus accumulator, sets c dc z
// - xor literal into accumulator, update zero
// - xor file to destination, update zero
// - instruction cycle is four oscillator periods
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none

module rix_core #(
  parameter logic [10:0] RESET_VECTOR = 11'h000 // first fetch address
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // program memory
  output logic      [10:0]               prog_addr,
  input  wire logic [11:0]               prog_rdata,
  // file register space
  output rix_pkg::rix_file_req_type      file_req,
  input  wire logic [7:0]                file_rdata,
  // wake pin and standby indication
  input  wire logic                      wake_pin,
  output logic                           osc_halted
);

  // instruction cycle phase counter
  logic [1:0] phase;
  logic [1:0] next_phase;
  logic       cyc_end;                   // last oscillator period of a cycle

  // architectural state
  rix_pkg::rix_state_type state, next_state;
  logic [10:0] program_counter, next_program_counter;
  logic [11:0] ir, next_ir;              // instruction under execution
  logic [7:0]  acc, next_acc;            // working accumulator
  logic [7:0]  status, next_status;      // flag byte
  logic [10:0] stack_top, next_stack_top;
  logic [10:0] stack_low, next_stack_low;
  logic [7:0]  watchdog_counter, next_watchdog_counter;
  logic [7:0]  wd_prescale, next_wd_prescale;
  logic        flush, next_flush;        // second cycle of a two-cycle op
  rix_pkg::rix_file_req_type next_file_req;

  // control register
  logic [1:0] ctrl, next_ctrl;

  // apb read path
  logic [31:0] next_prdata;
  logic        miss, next_miss;          // unmapped address seen in setup

  // wake pin synchroniser
  logic sync1, sync2, sync3;
  logic pin_level, next_pin_level;

  // decode a word into an operation
  function automatic rix_pkg::rix_op_type decode(input logic [11:0] w);
    rix_pkg::rix_op_type o;
    o = rix_pkg::OP_NONE;
    if (w == rix_pkg::WDCLR_WORD) begin
      o = rix_pkg::OP_WDCLR;
    end else if (w == rix_pkg::SLEEP_WORD) begin
      o = rix_pkg::OP_SLEEP;
    end else if (w == rix_pkg::CLRACC_WORD) begin
      o = rix_pkg::OP_CLRACC;
    end else if (w[11:5] == rix_pkg::CLRFILE_PFX) begin
      o = rix_pkg::OP_CLRFILE;
    end else if (w[11:6] == rix_pkg::DEC_PFX) begin
      o = rix_pkg::OP_DEC;
    end else if (w[11:6] == rix_pkg::DECSKIP_PFX) begin
      o = rix_pkg::OP_DECSKIP;
    end else if (w[11:6] == rix_pkg::ORFILE_PFX) begin
      o = rix_pkg::OP_ORFILE;
    end else if (w[11:6] == rix_pkg::MOVFILE_PFX) begin
      o = rix_pkg::OP_MOVFILE;
    end else if (w[11:6] == rix_pkg::SUB_PFX) begin
      o = rix_pkg::OP_SUB;
    end else if (w[11:6] == rix_pkg::XORFILE_PFX) begin
      o = rix_pkg::OP_XORFILE;
    end else if (w[11:8] == rix_pkg::CALL_PFX) begin
      o = rix_pkg::OP_CALL;
    end else if (w[11:9] == rix_pkg::BRANCH_PFX) begin
      o = rix_pkg::OP_BRANCH;
    end else if (w[11:8] == rix_pkg::ORLIT_PFX) begin
      o = rix_pkg::OP_ORLIT;
    end else if (w[11:8] == rix_pkg::MOVLIT_PFX) begin
      o = rix_pkg::OP_MOVLIT;
    end else if (w[11:8] == rix_pkg::XORLIT_PFX) begin
      o = rix_pkg::OP_XORLIT;
    end
    return o;
  endfunction

  // flag byte with zero flag set from a result
  function automatic logic [7:0] with_zero(input logic [7:0] st,
                                           input logic [7:0] r);
    logic [7:0] s;
    s = st;
    s[rix_pkg::ST_Z] = (r == 8'h00);
    return s;
  endfunction

  rix_pkg::rix_op_type op;
  logic        dest_file;                // destination bit of the word
  logic [7:0]  result;
  logic [8:0]  sub_sum;
  logic [4:0]  sub_nib;
  logic        apb_wr;
  logic        run_ok;

  assign op        = decode(ir);
  assign dest_file = ir[5];
  assign cyc_end   = (phase == 2'(rix_pkg::OSC_PER_CYCLE - 1));
  assign run_ok    = ctrl[rix_pkg::CTRL_RUN_BIT]
                     && (state == rix_pkg::ST_RUN);
  assign apb_wr    = psel && penable && pwrite;
  // access phase always completes in one cycle
  assign pready    = psel && penable;
  assign pslverr   = psel && penable && miss;
  assign osc_halted = (state == rix_pkg::ST_STANDBY);
  assign prog_addr = program_counter;

  // two's complement subtract: f + ~w + 1
  assign sub_sum = 9'({1'b0, file_rdata}) + 9'({1'b0, ~acc}) + 9'h001;
  assign sub_nib = 5'({1'b0, file_rdata[3:0]}) + 5'({1'b0, ~acc[3:0]})
                   + 5'h01;

  // wake pin: three flops, level accepted when last two agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= wake_pin;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // next-state logic of the whole core
  always_comb begin
    next_phase           = phase;
    next_state           = state;
    next_program_counter = program_counter;
    next_ir              = ir;
    next_acc             = acc;
    next_status          = status;
    next_stack_top       = stack_top;
    next_stack_low       = stack_low;
    next_watchdog_counter = watchdog_counter;
    next_wd_prescale     = wd_prescale;
    next_flush           = flush;
    next_ctrl            = ctrl;
    next_pin_level       = pin_level;
    next_file_req        = file_req;
    next_file_req.we     = 1'b0;         // strobe lasts one pclk
    next_file_req.addr   = ir[4:0];
    result               = 8'h00;

    // filtered pin level
    if (sync2 == sync3) begin
      next_pin_level = sync3;
    end

    // phase runs only while executing, so standby freezes the cycle
    if (run_ok) begin
      next_phase = cyc_end ? 2'h0 : 2'(phase + 2'h1);
    end

    // watchdog ticks once per instruction cycle, via prescaler if set
    if (run_ok && cyc_end) begin
      if (ctrl[rix_pkg::CTRL_PSA_BIT]) begin
        next_wd_prescale = 8'(wd_prescale + 8'h01);
        if (wd_prescale == 8'hFF) begin
          next_watchdog_counter = 8'(watchdog_counter + 8'h01);
        end
      end else begin
        next_watchdog_counter = 8'(watchdog_counter + 8'h01);
      end
    end

    // execute at the end of each instruction cycle
    if (run_ok && cyc_end) begin
      // fetch the word at the counter; a flush turns it into a nop
      next_ir              = prog_rdata;
      next_program_counter = 11'(program_counter + 11'h001);
      next_flush           = 1'b0;
      if (!flush) begin
        unique case (op)
          rix_pkg::OP_CALL: begin
            // oldest entry lost on overflow, no flag raised
            next_stack_low = stack_top;
            next_stack_top = program_counter;
            next_program_counter = {status[rix_pkg::ST_PA1],
                                    status[rix_pkg::ST_PA0],
                                    1'b0, ir[7:0]};
            next_ir    = rix_pkg::NOP_WORD;
            next_flush = 1'b1;
          end
          rix_pkg::OP_BRANCH: begin
            next_program_counter = {status[rix_pkg::ST_PA1],
                                    status[rix_pkg::ST_PA0],
                                    ir[8:0]};
            next_ir    = rix_pkg::NOP_WORD;
            next_flush = 1'b1;
          end
          rix_pkg::OP_CLRFILE: begin
            next_file_req.wdata = 8'h00;
            next_file_req.we    = 1'b1;
            next_status[rix_pkg::ST_Z] = 1'b1;
          end
          rix_pkg::OP_CLRACC: begin
            next_acc = 8'h00;
            next_status[rix_pkg::ST_Z] = 1'b1;
          end
          rix_pkg::OP_WDCLR: begin
            next_watchdog_counter = 8'h00;
            // prescaler cleared only when the watchdog owns it
            if (ctrl[rix_pkg::CTRL_PSA_BIT]) begin
              next_wd_prescale = 8'h00;
            end
            next_status[rix_pkg::ST_TO] = 1'b1;
            next_status[rix_pkg::ST_PD] = 1'b1;
          end
          rix_pkg::OP_SLEEP: begin
            next_watchdog_counter = 8'h00;
            next_wd_prescale      = 8'h00;
            next_status[rix_pkg::ST_TO] = 1'b1;
            next_status[rix_pkg::ST_PD] = 1'b0;
            next_state = rix_pkg::ST_STANDBY;
          end
          rix_pkg::OP_DEC, rix_pkg::OP_DECSKIP: begin
            result = 8'(file_rdata - 8'h01);
            if (op == rix_pkg::OP_DEC) begin
              next_status = with_zero(status, result);
            end else if (result == 8'h00) begin
              // flags untouched; fetched word discarded
              next_ir    = rix_pkg::NOP_WORD;
              next_flush = 1'b1;
            end
          end
          rix_pkg::OP_ORFILE: begin
            result      = acc | file_rdata;
            next_status = with_zero(status, result);
          end
          rix_pkg::OP_XORFILE: begin
            result      = acc ^ file_rdata;
            next_status = with_zero(status, result);
          end
          rix_pkg::OP_MOVFILE: begin
            // zero updated even for a copy onto itself
            result      = file_rdata;
            next_status = with_zero(status, result);
          end
          rix_pkg::OP_SUB: begin
            result = sub_sum[7:0];
            next_status = with_zero(status, result);
            next_status[rix_pkg::ST_C]  = sub_sum[8];
            next_status[rix_pkg::ST_DC] = sub_nib[4];
          end
          rix_pkg::OP_ORLIT: begin
            next_acc    = acc | ir[7:0];
            next_status = with_zero(status, acc | ir[7:0]);
          end
          rix_pkg::OP_XORLIT: begin
            next_acc    = acc ^ ir[7:0];
            next_status = with_zero(status, acc ^ ir[7:0]);
          end
          rix_pkg::OP_MOVLIT: begin
            next_acc = ir[7:0];
          end
          rix_pkg::OP_NONE: begin
            // words outside this subset run as no-operation
          end
        endcase
        // file operations with a destination bit
        if (op inside {rix_pkg::OP_DEC, rix_pkg::OP_DECSKIP,
                       rix_pkg::OP_ORFILE, rix_pkg::OP_XORFILE,
                       rix_pkg::OP_MOVFILE, rix_pkg::OP_SUB}) begin
          if (dest_file) begin
            next_file_req.wdata = result;
            next_file_req.we    = 1'b1;
          end else begin
            next_acc = result;
          end
        end
      end
    end

    // standby ends on a filtered high wake level
    if (state == rix_pkg::ST_STANDBY && pin_level) begin
      next_state = rix_pkg::ST_RUN;
      next_status[rix_pkg::ST_WUF] = 1'b1;
    end

    // apb writes: page bits and wake flag of status, control
    if (apb_wr) begin
      unique case (paddr)
        rix_pkg::CTRL_OFS: next_ctrl = pwdata[1:0];
        rix_pkg::STATUS_OFS: begin
          next_status[rix_pkg::ST_PA0] = pwdata[rix_pkg::ST_PA0];
          next_status[rix_pkg::ST_PA1] = pwdata[rix_pkg::ST_PA1];
          // a wake event in the same cycle beats the clear
          if (!(state == rix_pkg::ST_STANDBY && pin_level)) begin
            next_status[rix_pkg::ST_WUF] = pwdata[rix_pkg::ST_WUF];
          end
        end
        default: begin
          // read-only or unmapped: write ignored
        end
      endcase
    end
  end

  // apb read data captured in the setup cycle
  always_comb begin
    next_prdata = prdata;
    next_miss   = miss;
    if (psel && !penable) begin
      next_miss   = 1'b0;
      next_prdata = 32'h0000_0000;
      unique case (paddr)
        rix_pkg::CTRL_OFS:   next_prdata = 32'({ctrl});
        rix_pkg::STATUS_OFS: next_prdata = 32'({status});
        rix_pkg::ACC_OFS:    next_prdata = 32'({acc});
        rix_pkg::PC_OFS:     next_prdata = 32'({program_counter});
        rix_pkg::WDOG_OFS:   next_prdata = 32'({wd_prescale,
                                                watchdog_counter});
        default:             next_miss   = 1'b1;
      endcase
    end
  end

  // registers of the core and of the bus slave
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase            <= 2'h0;
      state            <= rix_pkg::ST_RUN;
      program_counter  <= RESET_VECTOR;
      ir               <= rix_pkg::NOP_WORD;
      acc              <= 8'h00;
      status           <= rix_pkg::STATUS_RESET;
      stack_top        <= 11'h000;
      stack_low        <= 11'h000;
      watchdog_counter <= 8'h00;
      wd_prescale      <= 8'h00;
      flush            <= 1'b0;
      ctrl             <= rix_pkg::CTRL_RESET;
      pin_level        <= 1'b0;
      file_req         <= '0;
      prdata           <= 32'h0000_0000;
      miss             <= 1'b0;
    end else begin
      phase            <= next_phase;
      state            <= next_state;
      program_counter  <= next_program_counter;
      ir               <= next_ir;
      acc              <= next_acc;
      status           <= next_status;
      stack_top        <= next_stack_top;
      stack_low        <= next_stack_low;
      watchdog_counter <= next_watchdog_counter;
      wd_prescale      <= next_wd_prescale;
      flush            <= next_flush;
      ctrl             <= next_ctrl;
      pin_level        <= next_pin_level;
      file_req         <= next_file_req;
      prdata           <= next_prdata;
      miss             <= next_miss;
    end
  end

endmodule

`default_nettype wire

// >>> sim/rix_core_sva.sv
// checker: port-level properties of the execute core
`timescale 1ns/10ps
`default_nettype none

module rix_core_sva #(
  parameter logic [10:0] RESET_VECTOR = 11'h000 // first fetch address
) (
  input wire logic                      pclk,
  input wire logic                      presetn,
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [7:0]                paddr,
  input wire logic [31:0]               pwdata,
  input wire logic [31:0]               prdata,
  input wire logic                      pready,
  input wire logic                      pslverr,
  input wire logic [10:0]               prog_addr,
  input wire logic [11:0]               prog_rdata,
  input wire rix_pkg::rix_file_req_type file_req,
  input wire logic [7:0]                file_rdata,
  input wire logic                      wake_pin,
  input wire logic                      osc_halted
);
  default clocking dcb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc_cyc; // access phase of an apb transfer
  assign acc_cyc = psel && penable;
  // zero wait states, no answer outside the access phase
  a_ready_access: assert property (acc_cyc |-> pready)
    else $error("pready low in access phase");
  a_ready_idle: assert property (!acc_cyc |-> !pready && !pslverr)
    else $error("answer outside access phase");
  a_err_unmapped: assert property (acc_cyc && paddr > 8'h10 |-> pslverr)
    else $error("unmapped access not refused");
  // first fetch comes from the reset vector
  a_fetch_start: assert property ($rose(presetn) |-> prog_addr == RESET_VECTOR)
    else $error("first fetch not at reset vector");
  // fetch moves at most once per four pclk
  a_cycle_four: assert property (
    $changed(prog_addr) |=> $stable(prog_addr) [*3])
    else $error("instruction cycle shorter than four pclk");
  // standby freezes fetch and file writes
  a_halt_frozen: assert property (
    osc_halted && $past(osc_halted) |-> $stable(prog_addr))
    else $error("fetch moved in standby");
  a_halt_quiet: assert property (
    osc_halted && $past(osc_halted) |-> !file_req.we)
    else $error("file written in standby");
  // at most one routed write per instruction cycle
  a_write_single: assert property (
    file_req.we |=> !file_req.we [*3])
    else $error("file strobe repeated within a cycle");
endmodule

bind rix_core rix_core_sva #(.RESET_VECTOR(RESET_VECTOR)) i_rix_core_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .prog_addr(prog_addr),
  .prog_rdata(prog_rdata), .file_req(file_req), .file_rdata(file_rdata),
  .wake_pin(wake_pin), .osc_halted(osc_halted)
);
`default_nettype wire

// >>> sim/rix_mem_model.sv
// partner: program memory and file register space
`timescale 1ns/10ps
`default_nettype none

module rix_mem_model (
  input  wire logic                      pclk,
  input  wire logic [10:0]               prog_addr,
  output logic      [11:0]               prog_rdata,
  input  wire rix_pkg::rix_file_req_type file_req,
  output logic      [7:0]                file_rdata
);
  logic [11:0] prog [2048]; // words, loaded by the bench in reset
  logic [7:0]  regs [32];   // file registers, preloaded by the bench
  // fetch and operand read are combinational, as the core expects
  assign prog_rdata = prog[prog_addr];
  assign file_rdata = regs[file_req.addr];
  // strobe lands the routed result; plain always so the bench may preload
  always @(posedge pclk) begin
    if (file_req.we === 1'b1) begin
      regs[file_req.addr] <= file_req.wdata;
    end
  end
endmodule
`default_nettype wire

// >>> sim/rix_core_test.sv
// bench: runs short programs on the execute core and checks results
`timescale 1ns/10ps
`default_nettype none

module rix_core_test;
  logic                      pclk, presetn, psel, penable, pwrite;
  logic                      pready, pslverr, wake_pin, osc_halted;
  logic [7:0]                paddr, file_rdata;
  logic [31:0]               pwdata, prdata;
  logic [10:0]               prog_addr;
  logic [11:0]               prog_rdata;
  rix_pkg::rix_file_req_type file_req;
  logic [31:0]               rd;     // last read word
  logic                      rd_err; // last error answer
  int                        n_mismatch;
  int                        samples_checked;

  rix_core i_rix_core (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .prog_addr(prog_addr),
    .prog_rdata(prog_rdata), .file_req(file_req), .file_rdata(file_rdata),
    .wake_pin(wake_pin), .osc_halted(osc_halted)
  );
  rix_mem_model i_rix_mem_model (
    .pclk(pclk), .prog_addr(prog_addr), .prog_rdata(prog_rdata),
    .file_req(file_req), .file_rdata(file_rdata)
  );

  // 100 mhz bus clock
  always #5 pclk = ~pclk;

  // verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // one compare, counted
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("unexpected %s: expected %h seen %h", s, e, g);
      n_mismatch++;
    end
  endtask
  // one apb transfer; data and error taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    rd_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string s, input logic [7:0] a,
                      input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(s, e, rd);
  endtask
  task automatic fchk(input int i, input logic [7:0] e);
    chk($sformatf("file %0d", i), {24'h00_0000, e},
        {24'h00_0000, i_rix_mem_model.regs[i]});
  endtask
  // reset held ten cycles; memories wiped meanwhile
  task automatic hold_reset();
    int i;
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    for (i = 0; i < 2048; i++) i_rix_mem_model.prog[i] = 12'h000;
    for (i = 0; i < 32; i++) i_rix_mem_model.regs[i] = 8'h00;
  endtask
  task automatic put(input logic [10:0] a, input logic [11:0] w);
    i_rix_mem_model.prog[a] = w;
  endtask
  // bounded wait for standby; a runaway program never gets there
  task automatic wait_halt();
    int i;
    for (i = 0; i < 600 && osc_halted !== 1'b1; i++) @(posedge pclk);
    chk("standby", 32'h0000_0001, {31'h0000_0000, osc_halted});
  endtask

  // cuts a hang short
  initial begin
    #200_000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    int i;
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    wake_pin = 1'b0;
    n_mismatch = 0;
    samples_checked = 0;
    // literal and file logic, both destinations, subtract flags
    hold_reset();
    i_rix_mem_model.regs[5] = 8'h03;
    i_rix_mem_model.regs[7] = 8'h03;
    put(11'h000, {rix_pkg::MOVLIT_PFX, 8'h9a});
    put(11'h001, {rix_pkg::ORLIT_PFX, 8'h35});
    put(11'h002, {rix_pkg::XORLIT_PFX, 8'haf});
    put(11'h003, {rix_pkg::ORFILE_PFX, 1'b1, 5'h0c});
    put(11'h004, {rix_pkg::ORFILE_PFX, 1'b1, 5'h05});
    put(11'h005, {rix_pkg::XORFILE_PFX, 1'b0, 5'h05});
    put(11'h006, {rix_pkg::SUB_PFX, 1'b1, 5'h07});
    put(11'h007, {rix_pkg::SUB_PFX, 1'b0, 5'h07});
    put(11'h008, {rix_pkg::ORFILE_PFX, 1'b1, 5'h0d});
    put(11'h009, {rix_pkg::MOVFILE_PFX, 1'b1, 5'h09});
    put(11'h00a, {rix_pkg::MOVLIT_PFX, 8'h5a});
    put(11'h00b, rix_pkg::SLEEP_WORD);
    presetn <= 1'b1;
    wait_halt();
    fchk(12, 8'h10);
    fchk(5, 8'h13);
    fchk(7, 8'h00);
    fchk(13, 8'hfd);
    rchk("acc", rix_pkg::ACC_OFS, 32'h0000_005a);
    rchk("status", rix_pkg::STATUS_OFS, 32'h0000_0014);
    $display("test alu done");
    // skip, call, branch with page bits from status
    hold_reset();
    i_rix_mem_model.regs[8] = 8'h5a;
    i_rix_mem_model.regs[10] = 8'h02;
    put(11'h006, {rix_pkg::DEC_PFX, 1'b0, 5'h08});
    put(11'h007, {rix_pkg::ORFILE_PFX, 1'b1, 5'h0f});
    put(11'h008, {rix_pkg::CLRFILE_PFX, 5'h08});
    put(11'h009, rix_pkg::CLRACC_WORD);
    put(11'h00a, {rix_pkg::ORLIT_PFX, 8'h01});
    put(11'h00b, {rix_pkg::DECSKIP_PFX, 1'b1, 5'h0a});
    put(11'h00c, {rix_pkg::DECSKIP_PFX, 1'b1, 5'h0a});
    put(11'h00d, {rix_pkg::MOVLIT_PFX, 8'h77});
    put(11'h00e, {rix_pkg::CALL_PFX, 8'h40});
    // three nested calls: the first return address falls off the stack
    put(11'h240, {rix_pkg::CALL_PFX, 8'h80});
    put(11'h280, {rix_pkg::CALL_PFX, 8'hc0});
    put(11'h2c0, {rix_pkg::BRANCH_PFX, 9'h1f0});
    put(11'h3f0, rix_pkg::WDCLR_WORD);
    put(11'h3f1, rix_pkg::SLEEP_WORD);
    // already fetched behind the sleep, runs right after the wake
    put(11'h3f2, rix_pkg::WDCLR_WORD);
    presetn <= 1'b1;
    rchk("status reset", rix_pkg::STATUS_OFS, 32'h0000_0018);
    rchk("ctrl reset", rix_pkg::CTRL_OFS, 32'h0000_0001);
    // only the upper three bits take the write
    apb(1'b1, rix_pkg::STATUS_OFS, 32'h0000_003f);
    rchk("status page", rix_pkg::STATUS_OFS, 32'h0000_0038);
    wait_halt();
    chk("stack top", 32'h0000_0281, {21'h0_0000, i_rix_core.stack_top});
    chk("stack low", 32'h0000_0241, {21'h0_0000, i_rix_core.stack_low});
    fchk(15, 8'h59);
    fchk(8, 8'h00);
    fchk(10, 8'h00);
    rchk("acc", rix_pkg::ACC_OFS, 32'h0000_0001);
    rchk("status", rix_pkg::STATUS_OFS, 32'h0000_0030);
    rchk("watchdog", rix_pkg::WDOG_OFS, 32'h0000_0000);
    $display("test flow done");
    // wake, read-only and unmapped places, run control
    wake_pin <= 1'b1;
    for (i = 0; i < 20 && osc_halted === 1'b1; i++) @(posedge pclk);
    // two instruction cycles: the queued watchdog clear sets powerdown
    repeat (8) @(posedge pclk);
    rchk("wake flag", rix_pkg::STATUS_OFS, 32'h0000_00b8);
    wake_pin <= 1'b0;
    apb(1'b1, rix_pkg::ACC_OFS, 32'h0000_00ee);
    rchk("acc kept", rix_pkg::ACC_OFS, 32'h0000_0001);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, {31'h0000_0000, rd_err});
    chk("unmapped data", 32'h0000_0000, rd);
    apb(1'b1, rix_pkg::CTRL_OFS, 32'h0000_0002);
    rchk("ctrl", rix_pkg::CTRL_OFS, 32'h0000_0002);
    apb(1'b0, rix_pkg::PC_OFS, 32'h0000_0000);
    repeat (20) @(posedge pclk);
    rchk("pc stopped", rix_pkg::PC_OFS, rd);
    $display("test bus done");
    stop_test();
  end
endmodule
`default_nettype wire
